// File: design/output_shutdown_pkg.sv
package output_shutdown_pkg;

  localparam int NUM_INPUTS = 4;
  localparam int NUM_PINS   = 6;

  // register word index, byte address is four times the index
  localparam logic [2:0] IDX_IN_CTRL   = 3'h0;
  localparam logic [2:0] IDX_OUT_CTRL  = 3'h1;
  localparam logic [2:0] IDX_IRQ_STAT  = 3'h2;
  localparam logic [2:0] IDX_IRQ_MASK  = 3'h3;
  localparam logic [2:0] IDX_PIN_SEL   = 3'h4;
  localparam int         ADR_W         = 5;

  // input_shutdown_ctrl_status fields
  localparam int IN_MODE_LSB  = 0;
  localparam int IN_IE_BIT    = 8;
  localparam int IN_FLAG_LSB  = 12;
  // output_compare_ctrl_status fields
  localparam int OUT_IE_BIT   = 8;
  localparam int OUT_CE_BIT   = 9;
  localparam int OUT_FLAG_BIT = 15;
  // interrupt status and mask fields
  localparam int IRQ_IN_BIT   = 0;
  localparam int IRQ_OUT_BIT  = 1;

  localparam logic [15:0] IN_CTRL_RESET  = 16'h0000;
  localparam logic [15:0] OUT_CTRL_RESET = 16'h0000;
  localparam logic [1:0]  IRQ_MASK_RESET = 2'h0;
  localparam logic [5:0]  PIN_SEL_RESET  = 6'h3f;

  // detection mode per shutdown input
  typedef enum logic [1:0] {
    MODE_EDGE     = 2'b00,
    MODE_LOW_8    = 2'b01,
    MODE_LOW_16   = 2'b10,
    MODE_LOW_128  = 2'b11
  } detect_mode_t;

  localparam int         PRESC_W       = 7;
  localparam logic [6:0] DIV8_MASK     = 7'h07;
  localparam logic [6:0] DIV16_MASK    = 7'h0f;
  localparam logic [6:0] DIV128_MASK   = 7'h7f;
  localparam logic [4:0] SAMPLE_COUNT  = 5'h10;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } bus_state_t;

endpackage

// File: design/shutdown_input_detect.sv
`timescale 1ns/1ps
`default_nettype none

module shutdown_input_detect (
  input  wire logic                               clk_i,
  input  wire logic                               rst_i,
  input  wire logic                               shutdown_n_i,
  input  wire output_shutdown_pkg::detect_mode_t  mode_i,
  input  wire logic                               tick8_i,
  input  wire logic                               tick16_i,
  input  wire logic                               tick128_i,
  output logic                                    detect_o
);
  import output_shutdown_pkg::*;

  typedef struct packed {
    logic       sync1;
    logic       sync2;
    logic       prev;
    logic [4:0] low_cnt;
    logic       det;
  } det_state_t;

  det_state_t q;
  det_state_t d;
  logic       tick;

  always_comb begin
    d       = q;
    d.sync1 = shutdown_n_i;
    d.sync2 = q.sync1;
    d.prev  = q.sync2;
    d.det   = 1'b0;
    case (mode_i)
      MODE_LOW_8:   tick = tick8_i;
      MODE_LOW_16:  tick = tick16_i;
      MODE_LOW_128: tick = tick128_i;
      default:      tick = 1'b0;
    endcase
    if (mode_i == MODE_EDGE) begin
      d.low_cnt = 5'h00;
      d.det     = q.prev & ~q.sync2;
    end else if (tick) begin
      if (q.sync2) begin
        d.low_cnt = 5'h00;
      end else if (q.low_cnt != SAMPLE_COUNT) begin
        d.low_cnt = q.low_cnt + 5'h01;
        d.det     = (q.low_cnt == SAMPLE_COUNT - 5'h01);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.sync1 <= 1'b1;
      q.sync2 <= 1'b1;
      q.prev  <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign detect_o = q.det;

endmodule

`default_nettype wire

// File: design/output_pair_compare.sv
`timescale 1ns/1ps
`default_nettype none

module output_pair_compare (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       enable_i,
  input  wire logic [5:0] level_i,
  input  wire logic [5:0] drive_i,
  output logic            short_o
);

  typedef struct packed {
    logic short_det;
  } cmp_state_t;

  cmp_state_t q;
  cmp_state_t d;

  function automatic logic both_low(input logic [5:0] lvl, input logic [5:0] drv,
                                    input int a, input int b);
    both_low = drv[a] & drv[b] & ~lvl[a] & ~lvl[b];
  endfunction

  // pairs: ch3 b/d, ch4 a/c, ch4 b/d
  always_comb begin
    d           = q;
    d.short_det = enable_i & (both_low(level_i, drive_i, 0, 1)
                           | both_low(level_i, drive_i, 2, 4)
                           | both_low(level_i, drive_i, 3, 5));
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign short_o = q.short_det;

endmodule

`default_nettype wire

// File: design/output_shutdown_unit.sv
// Summary of operation
// - Each of four shutdown inputs selects falling-edge or low sampling at clk/8, /16 or /128.
// - A met detection condition puts the high-current pins into high impedance.
// - Paired outputs driven low together for one clock or more force high impedance.
// - Input detection and output short each request an interrupt under their own enable.
// - Oscillator stop or standby puts the pins into high impedance whatever function is on them.
// - The six protected pins are ch3 out b, ch3 out d and ch4 outs a, b, c and d.
// - A 16-bit input register holds the modes, the input interrupt enable and four flags.
// - A 16-bit output register holds compare enable, its interrupt enable and the short flag.
// - Any single input detection shuts down every protected pin whose pin_sel bit is set.
// - Low mode accepts only sixteen consecutive low samples; one high restarts the run.
// - Input shutdown is released only by reset, by clearing all four input flags or, per pin, by clearing its pin_sel bit.
// - Output shutdown is released by reset or by clearing compare enable, then the flag.
// - A flag clears only on a write of 0 after it was read as 1.
`timescale 1ns/1ps
`default_nettype none

module output_shutdown_unit (
  input  wire logic                                   clk_i,
  input  wire logic                                   rst_i,
  input  wire logic [output_shutdown_pkg::ADR_W-1:0]  adr_i,
  input  wire logic [31:0]                            dat_i,
  output logic      [31:0]                            dat_o,
  input  wire logic                                   we_i,
  input  wire logic [3:0]                             sel_i,
  input  wire logic                                   cyc_i,
  input  wire logic                                   stb_i,
  output logic                                        ack_o,
  input  wire logic [output_shutdown_pkg::NUM_INPUTS-1:0] shutdown_n_i,
  input  wire logic                                   osc_stop_i,
  input  wire logic                                   standby_i,
  input  wire logic [output_shutdown_pkg::NUM_PINS-1:0] timer_out_i,
  input  wire logic [output_shutdown_pkg::NUM_PINS-1:0] timer_oe_i,
  output logic      [output_shutdown_pkg::NUM_PINS-1:0] pin_o,
  output logic      [output_shutdown_pkg::NUM_PINS-1:0] pin_oe_o,
  output logic                                        irq_o
);
  import output_shutdown_pkg::*;

  typedef struct packed {
    bus_state_t      bus;
    logic            ack;
    logic [15:0]     rdata;
    logic [6:0]      presc;
    logic [7:0]      in_mode;
    logic            in_ie;
    logic [3:0]      in_flag;
    logic [3:0]      in_armed;
    logic            out_ce;
    logic            out_ie;
    logic            out_flag;
    logic            out_armed;
    logic [1:0]      irq_stat;
    logic [1:0]      irq_mask;
    logic [5:0]      pin_sel;
    logic [5:0]      pin_lvl;
    logic [5:0]      pin_oe;
    logic            irq;
  } unit_state_t;

  unit_state_t q;
  unit_state_t d;

  logic [NUM_INPUTS-1:0] detect;
  logic                  short_det;
  logic                  tick8;
  logic                  tick16;
  logic                  tick128;

  function automatic logic presc_hit(input logic [6:0] cnt, input logic [6:0] mask);
    presc_hit = ((cnt & mask) == mask);
  endfunction

  assign tick8   = presc_hit(q.presc, DIV8_MASK);
  assign tick16  = presc_hit(q.presc, DIV16_MASK);
  assign tick128 = presc_hit(q.presc, DIV128_MASK);

  for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_in
    shutdown_input_detect u_det (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .shutdown_n_i (shutdown_n_i[i]),
      .mode_i       (detect_mode_t'(q.in_mode[2*i +: 2])),
      .tick8_i      (tick8),
      .tick16_i     (tick16),
      .tick128_i    (tick128),
      .detect_o     (detect[i])
    );
  end

  output_pair_compare u_cmp (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .enable_i (q.out_ce),
    .level_i  (timer_out_i),
    .drive_i  (timer_oe_i),
    .short_o  (short_det)
  );

  logic        req;
  logic        wr;
  logic        rd;
  logic [15:0] be;
  logic [15:0] wdat;
  logic [15:0] in_word;
  logic [15:0] out_word;
  logic [3:0]  in_clr;
  logic        out_clr;
  logic        in_hiz;
  logic [5:0]  hiz;
  logic [2:0]  idx;

  always_comb begin
    d       = q;
    req     = cyc_i & stb_i;
    idx     = adr_i[ADR_W-1:2];
    be      = {{8{sel_i[1]}}, {8{sel_i[0]}}};
    wdat    = dat_i[15:0];
    in_clr  = 4'h0;
    out_clr = 1'b0;
    wr      = 1'b0;
    rd      = 1'b0;

    in_word = 16'h0000;
    in_word[IN_MODE_LSB +: 8]        = q.in_mode;
    in_word[IN_IE_BIT]               = q.in_ie;
    in_word[IN_FLAG_LSB +: 4]        = q.in_flag;
    out_word = 16'h0000;
    out_word[OUT_IE_BIT]             = q.out_ie;
    out_word[OUT_CE_BIT]             = q.out_ce;
    out_word[OUT_FLAG_BIT]           = q.out_flag;

    d.presc = q.presc + 7'h01;

    case (q.bus)
      BUS_IDLE: begin
        d.ack = 1'b0;
        if (req) begin
          d.bus = BUS_ACK;
          d.ack = 1'b1;
          wr    = we_i;
          rd    = ~we_i;
        end
      end
      BUS_ACK: begin
        d.bus = BUS_IDLE;
        d.ack = 1'b0;
      end
      default: begin
        d.bus = BUS_IDLE;
        d.ack = 1'b0;
      end
    endcase

    if (rd) begin
      case (idx)
        IDX_IN_CTRL: begin
          d.rdata    = in_word;
          d.in_armed = q.in_flag;
        end
        IDX_OUT_CTRL: begin
          d.rdata     = out_word;
          d.out_armed = q.out_flag;
        end
        IDX_IRQ_STAT: begin
          d.rdata    = {14'h0000, q.irq_stat};
          d.irq_stat = 2'h0;
        end
        IDX_IRQ_MASK: d.rdata = {14'h0000, q.irq_mask};
        IDX_PIN_SEL:  d.rdata = {10'h000, q.pin_sel};
        default:      d.rdata = 16'h0000;
      endcase
    end

    if (wr) begin
      case (idx)
        IDX_IN_CTRL: begin
          // reserved bits are not stored, so they read back as zero
          d.in_mode = (q.in_mode & ~be[7:0]) | (wdat[7:0] & be[7:0]);
          if (be[IN_IE_BIT]) begin
            d.in_ie = wdat[IN_IE_BIT];
          end
          in_clr     = q.in_armed & be[IN_FLAG_LSB +: 4]
                     & ~wdat[IN_FLAG_LSB +: 4];
          d.in_armed = 4'h0;
        end
        IDX_OUT_CTRL: begin
          if (be[OUT_IE_BIT]) begin
            d.out_ie = wdat[OUT_IE_BIT];
            d.out_ce = wdat[OUT_CE_BIT];
          end
          out_clr     = q.out_armed & be[OUT_FLAG_BIT]
                      & ~wdat[OUT_FLAG_BIT];
          d.out_armed = 1'b0;
        end
        IDX_IRQ_MASK: begin
          if (be[0]) begin
            d.irq_mask = wdat[1:0];
          end
        end
        IDX_PIN_SEL: begin
          if (be[0]) begin
            d.pin_sel = wdat[5:0];
          end
        end
        default: begin
        end
      endcase
    end

    // a new detection wins over a clear in the same cycle
    d.in_flag  = (q.in_flag & ~in_clr) | detect;
    d.out_flag = (q.out_flag & ~out_clr) | short_det;

    // a read of the status clears it, but an event in that cycle still sets it
    if (q.in_ie & (|detect)) begin
      d.irq_stat[IRQ_IN_BIT] = 1'b1;
    end
    if (q.out_ie & short_det) begin
      d.irq_stat[IRQ_OUT_BIT] = 1'b1;
    end
    d.irq = |(d.irq_stat & q.irq_mask);

    in_hiz = |q.in_flag;
    hiz    = ({6{in_hiz}} & q.pin_sel)
           | {6{q.out_flag}}
           | {6{osc_stop_i | standby_i}};
    d.pin_lvl = timer_out_i;
    d.pin_oe  = timer_oe_i & ~hiz;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q          <= '0;
      q.in_mode  <= IN_CTRL_RESET[7:0];
      q.in_ie    <= IN_CTRL_RESET[IN_IE_BIT];
      q.out_ce   <= OUT_CTRL_RESET[OUT_CE_BIT];
      q.out_ie   <= OUT_CTRL_RESET[OUT_IE_BIT];
      q.irq_mask <= IRQ_MASK_RESET;
      q.pin_sel  <= PIN_SEL_RESET;
    end else begin
      q <= d;
    end
  end

  assign dat_o    = {16'h0000, q.rdata};
  assign ack_o    = q.ack;
  assign pin_o    = q.pin_lvl;
  assign pin_oe_o = q.pin_oe;
  assign irq_o    = q.irq;

endmodule

`default_nettype wire

// File: tb/output_shutdown_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module output_shutdown_monitor (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        ack_o,
  input wire logic [31:0] dat_o,
  input wire logic [3:0]  shutdown_n_i,
  input wire logic        osc_stop_i,
  input wire logic        standby_i,
  input wire logic [5:0]  timer_oe_i,
  input wire logic [5:0]  pin_oe_o,
  input wire logic        irq_o
);
  import output_shutdown_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held past one cycle");
  chk_ack_latency: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered next cycle");
  chk_read_upper: assert property (ack_o |-> dat_o[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  chk_hiz_standby: assert property (osc_stop_i || standby_i |=> pin_oe_o == 6'h00)
    else $error("pins driven during stop or standby");
  chk_drive_req: assert property (!rst_i |=> (pin_oe_o & ~$past(timer_oe_i)) == 6'h00)
    else $error("pin driven without request");
  chk_sync_delay: assert property (
    (|($past(shutdown_n_i) & ~shutdown_n_i)) && !osc_stop_i && !standby_i
    && timer_oe_i == 6'h3f && pin_oe_o == 6'h3f |=> (pin_oe_o == 6'h3f) [*2])
    else $error("shutdown acted before synchroniser");
  chk_all_at_once: assert property (
    $fell(pin_oe_o[5]) && $past(timer_oe_i) == 6'h3f |-> pin_oe_o == 6'h00)
    else $error("pins not shut down together");
  chk_reset_quiet: assert property (
    $fell(rst_i) |-> pin_oe_o == 6'h00 && !irq_o && !ack_o)
    else $error("outputs active after reset");
endmodule

bind output_shutdown_unit output_shutdown_monitor mon (.clk_i, .rst_i, .cyc_i, .stb_i,
  .ack_o, .dat_o, .shutdown_n_i, .osc_stop_i, .standby_i, .timer_oe_i, .pin_oe_o, .irq_o);

`default_nettype wire

// File: tb/fault_source_model.sv
`timescale 1ns/1ps
`default_nettype none

module fault_source_model (
  input  wire logic        clk_i,
  input  wire logic [1:0]  sel_i,
  input  wire logic [11:0] len_i,
  input  wire logic        go_i,
  output logic      [3:0]  shutdown_n_o
);
  logic [11:0] left_q;
  initial begin
    shutdown_n_o = 4'hf;
    left_q = 12'h000;
  end
  // released lines return high through their pull-ups
  always @(posedge clk_i) begin
    if (go_i) begin
      left_q <= len_i;
      shutdown_n_o <= ~(4'h1 << sel_i);
    end else if (left_q > 12'h001) begin
      left_q <= left_q - 12'h001;
    end else begin
      shutdown_n_o <= 4'hf;
    end
  end
endmodule

`default_nettype wire

// File: tb/output_shutdown_unit_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module output_shutdown_unit_tb_top;
  import output_shutdown_pkg::*;
  logic             clk_i, rst_i, cyc_i, stb_i, we_i, osc_stop_i, standby_i, ack_o, irq_o, go;
  logic [ADR_W-1:0] adr_i;
  logic [31:0]      dat_i, dat_o;
  logic [3:0]       sel_i, shutdown_n_i;
  logic [5:0]       timer_out_i, timer_oe_i, pin_o, pin_oe_o;
  logic [1:0]       fsel;
  logic [11:0]      flen;
  logic [15:0]      rd;
  logic [5:0]       pair_lo [3] = '{6'h3c, 6'h2b, 6'h17};
  int               n_mismatch, n_checks;

  output_shutdown_unit dut (.clk_i, .rst_i, .adr_i, .dat_i, .dat_o, .we_i, .sel_i, .cyc_i,
    .stb_i, .ack_o, .shutdown_n_i, .osc_stop_i, .standby_i, .timer_out_i, .timer_oe_i,
    .pin_o, .pin_oe_o, .irq_o);
  fault_source_model src (.clk_i, .sel_i(fsel), .len_i(flen), .go_i(go),
    .shutdown_n_o(shutdown_n_i));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", n, e, g);
      n_mismatch++;
    end
  endtask

  task automatic wb(input logic w, input logic [2:0] i, input logic [15:0] d);
    int k;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {i, 2'b00};
    dat_i <= {16'h0000, d};
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 20);
    if (ack_o !== 1'b1) begin
      n_mismatch++;
      conclude();
    end
    // read data is taken at the same edge that samples ack high
    rd = dat_o[15:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  task automatic rdc(input logic [2:0] i, input logic [15:0] e, input string n);
    wb(1'b0, i, 16'h0000);
    chk(n, e, rd);
  endtask

  task automatic wpin(input logic [5:0] e);
    int k;
    for (k = 0; k < 4000 && pin_oe_o !== e; k++) @(negedge clk_i);
    chk("pin_oe", {10'h000, e}, {10'h000, pin_oe_o});
    if (pin_oe_o !== e) begin
      conclude();
    end
  endtask

  task automatic fire(input logic [1:0] s, input logic [11:0] l);
    @(posedge clk_i);
    go <= 1'b1;
    fsel <= s;
    flen <= l;
    @(posedge clk_i);
    go <= 1'b0;
  endtask

  initial begin
    {rst_i, cyc_i, stb_i, we_i, osc_stop_i, standby_i, go} = 7'h40;
    {adr_i, dat_i, fsel, flen} = '0;
    sel_i = 4'h3;
    timer_out_i = 6'h3f;
    timer_oe_i = 6'h3f;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rdc(IDX_IN_CTRL, IN_CTRL_RESET, "in_ctrl");
    rdc(IDX_OUT_CTRL, OUT_CTRL_RESET, "out_ctrl");
    rdc(IDX_PIN_SEL, 16'h003f, "pin_sel");
    wb(1'b1, 3'h7, 16'hffff);
    rdc(3'h7, 16'h0000, "unmapped");
    wb(1'b1, IDX_IRQ_MASK, 16'h0003);
    wb(1'b1, IDX_IN_CTRL, 16'h0100);
    fire(2'd2, 12'h002);
    wpin(6'h00);
    chk("irq", 16'h0001, {15'h0000, irq_o});
    wb(1'b1, IDX_IN_CTRL, 16'h0100);
    rdc(IDX_IN_CTRL, 16'h4100, "flag kept");
    wb(1'b1, IDX_IN_CTRL, 16'h0100);
    rdc(IDX_IN_CTRL, 16'h0100, "flag clr");
    wpin(6'h3f);
    rdc(IDX_IRQ_STAT, 16'h0001, "irq stat");
    rdc(IDX_IRQ_STAT, 16'h0000, "stat clr");
    chk("irq", 16'h0000, {15'h0000, irq_o});
    for (int m = 1; m < 4; m++) begin
      int div;
      div = 8 << ((m == 3) ? 4 : m - 1);
      wb(1'b1, IDX_IN_CTRL, {8'h01, 6'h00, 2'(m)});
      fire(2'd0, 12'(div * 12));
      repeat (div * 16) @(posedge clk_i);
      rdc(IDX_IN_CTRL, {8'h01, 6'h00, 2'(m)}, "short low");
      fire(2'd0, 12'(div * 18));
      wpin(6'h00);
      rdc(IDX_IN_CTRL, {8'h11, 6'h00, 2'(m)}, "low det");
      wb(1'b1, IDX_IN_CTRL, {8'h01, 6'h00, 2'(m)});
      wpin(6'h3f);
      repeat (div * 4) @(posedge clk_i);
    end
    wb(1'b1, IDX_IN_CTRL, 16'h0100);
    wb(1'b0, IDX_IRQ_STAT, 16'h0000);
    foreach (pair_lo[p]) begin
      wb(1'b1, IDX_OUT_CTRL, 16'h0300);
      timer_out_i <= pair_lo[p];
      wpin(6'h00);
      @(posedge clk_i);
      timer_out_i <= 6'h3f;
      rdc(IDX_OUT_CTRL, 16'h8300, "short flag");
      wb(1'b1, IDX_OUT_CTRL, 16'h8100);
      rdc(IDX_OUT_CTRL, 16'h8100, "ce off");
      wb(1'b1, IDX_OUT_CTRL, 16'h0100);
      rdc(IDX_OUT_CTRL, 16'h0100, "short clr");
      wpin(6'h3f);
    end
    @(posedge clk_i);
    timer_out_i <= 6'h3a;
    wb(1'b1, IDX_OUT_CTRL, 16'h0300);
    rdc(IDX_OUT_CTRL, 16'h0300, "no pair");
    chk("pin_o", 16'h003a, {10'h000, pin_o});
    timer_out_i <= 6'h3f;
    wb(1'b1, IDX_OUT_CTRL, 16'h0100);
    rdc(IDX_IRQ_STAT, 16'h0002, "short irq");
    wb(1'b1, IDX_IRQ_MASK, 16'h0002);
    rdc(IDX_IRQ_MASK, 16'h0002, "irq mask");
    wb(1'b1, IDX_PIN_SEL, 16'h001f);
    fire(2'd1, 12'h002);
    wpin(6'h20);
    chk("irq masked", 16'h0000, {15'h0000, irq_o});
    rdc(IDX_IN_CTRL, 16'h2100, "flag1");
    wb(1'b1, IDX_IN_CTRL, 16'h0100);
    wpin(6'h3f);
    for (int s = 0; s < 2; s++) begin
      @(posedge clk_i);
      {osc_stop_i, standby_i} <= 2'b01 << s;
      wpin(6'h00);
      @(posedge clk_i);
      {osc_stop_i, standby_i} <= 2'b00;
      wpin(6'h3f);
    end
    // a mid-run reset must release an input shutdown and restore the registers
    fire(2'd3, 12'h002);
    wpin(6'h20);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wpin(6'h3f);
    rdc(IDX_IN_CTRL, IN_CTRL_RESET, "in_ctrl rst");
    rdc(IDX_PIN_SEL, {10'h000, PIN_SEL_RESET}, "pin_sel rst");
    conclude();
  end
endmodule

`default_nettype wire
